// ===== hw/sxs_exec.v
// execution slice: subtract, xor, nibble swap, rotate right, direction load and sleep entry
// assumes the core decoder presents one decoded instruction per execValid strobe with the
// addressed file value already read; software sees the state through an apb slave
`timescale 1ns/1ns
`include "sxs_consts.vh"
module sxs_exec #(
   parameter WATCH_PRE_W = 8,
   parameter WATCH_CNT_W = 8
) (
   // clock, reset, enable
   input  wire        core_clk,
   input  wire        arst_n,
   input  wire        clkEn,
   // decoded instruction
   input  wire        execValid,
   input  wire [3:0]  execOp,
   input  wire [7:0]  execLit,
   input  wire [6:0]  execFileAddr,
   input  wire        execDest,
   input  wire [7:0]  fileRdData,
   output wire        execReady,
   // file register write-back
   output reg         fileWrEn,
   output reg  [6:0]  fileWrAddr,
   output reg  [7:0]  fileWrData,
   // core state
   output reg  [7:0]  accOut,
   output reg         carryFlag,
   output reg         digitCarryFlag,
   output reg         zeroFlag,
   output reg         sleepEnteredNFlag,
   output reg         watchdogExpiryNFlag,
   output reg  [7:0]  portADirection,
   output reg  [7:0]  portBDirection,
   output reg  [7:0]  portCDirection,
   output reg         haltExec,
   output reg         oscRun,
   // sleep exit request
   input  wire        wakeReq,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output reg         pslverr
);
   // ***************************************************
   // reset and operand path
   // ***************************************************
   wire                   rst_n;
   wire [7:0]             aluResult;
   wire                   aluCarry;
   wire                   aluDigitCarry;
   wire                   aluZero;
   wire                   updCarry;
   wire                   updDigitCarry;
   wire                   updZero;
   wire                   take;
   wire                   destIsFile;
   wire                   writesAcc;
   reg  [WATCH_PRE_W-1:0] watchPre_r;
   reg  [WATCH_CNT_W-1:0] watchdogCounter;

   sxs_rst_sync u_rst (
      .core_clk  (core_clk),
      .arst_n    (arst_n),
      .rstSync_n (rst_n)
   );

   sxs_alu u_alu (
      .op            (execOp),
      .acc           (accOut),
      .fileVal       (fileRdData),
      .lit           (execLit),
      .carryIn       (carryFlag),
      .result        (aluResult),
      .carryOut      (aluCarry),
      .digitCarryOut (aluDigitCarry),
      .zeroOut       (aluZero),
      .updCarry      (updCarry),
      .updDigitCarry (updDigitCarry),
      .updZero       (updZero)
   );

   // instructions are refused while asleep; the core must hold them off
   assign execReady  = ~haltExec;
   assign take       = clkEn & execValid & execReady;
   assign destIsFile = execDest & (execOp == `SXS_OP_FILE_SUB  || execOp == `SXS_OP_FILE_SUBB ||
                                   execOp == `SXS_OP_NIB_SWAP  || execOp == `SXS_OP_XOR_FILE  ||
                                   execOp == `SXS_OP_ROT_RIGHT);
   assign writesAcc  = (execOp == `SXS_OP_LIT_SUB) | (execOp == `SXS_OP_XOR_LIT) |
                       (~execDest & (execOp == `SXS_OP_FILE_SUB  || execOp == `SXS_OP_FILE_SUBB ||
                                     execOp == `SXS_OP_NIB_SWAP  || execOp == `SXS_OP_XOR_FILE  ||
                                     execOp == `SXS_OP_ROT_RIGHT));

   // ***************************************************
   // apb decode
   // ***************************************************
   wire        apbSetup;
   wire        apbWr;
   wire        mapped;
   wire        sleepOp;
   wire        wakeUp;
   wire        apbWake;
   reg  [31:0] readMux;

   // zero wait states; a low enable stalls the access
   assign pready   = clkEn;
   assign apbSetup = clkEn & psel & ~penable;
   assign apbWr    = clkEn & psel & penable & pwrite & mapped;
   assign mapped   = (paddr == `SXS_REG_ACC)    |
                     (paddr == `SXS_REG_STATUS) |
                     (paddr == `SXS_REG_DIR_A)  |
                     (paddr == `SXS_REG_DIR_B)  |
                     (paddr == `SXS_REG_DIR_C)  |
                     (paddr == `SXS_REG_SLEEP)  |
                     (paddr == `SXS_REG_WATCH);
   assign sleepOp  = take & (execOp == `SXS_OP_SLEEP);
   // software can end sleep too
   assign apbWake  = apbWr & (paddr == `SXS_REG_SLEEP) & pwdata[`SXS_SLP_ASLEEP];
   assign wakeUp   = clkEn & haltExec & (wakeReq | apbWake);

   always @* begin
      readMux = 32'h0000_0000;
      case (paddr)
         `SXS_REG_ACC:    readMux[7:0] = accOut;
         `SXS_REG_STATUS: readMux[4:0] = {watchdogExpiryNFlag,
                                          sleepEnteredNFlag,
                                          zeroFlag,
                                          digitCarryFlag,
                                          carryFlag};
         `SXS_REG_DIR_A:  readMux[7:0] = portADirection;
         `SXS_REG_DIR_B:  readMux[7:0] = portBDirection;
         `SXS_REG_DIR_C:  readMux[7:0] = portCDirection;
         `SXS_REG_SLEEP:  readMux[0]   = haltExec;
         `SXS_REG_WATCH:  readMux[WATCH_CNT_W-1:0] = watchdogCounter;
         default:         readMux = 32'h0000_0000;
      endcase
   end

   // read data is captured in setup so the zero-wait access phase presents it from a flop
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (clkEn) begin
         if (apbSetup) begin
            prdata  <= pwrite ? 32'h0000_0000 : readMux;
            pslverr <= ~mapped;
         end else if (!psel) begin
            pslverr <= 1'b0;
         end
      end
   end

   // ***************************************************
   // accumulator, flags and write-back
   // ***************************************************
   // an instruction taken in the same cycle as a bus write to the same state wins
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         accOut         <= `SXS_RST_ACC;
         carryFlag      <= 1'b0;
         digitCarryFlag <= 1'b0;
         zeroFlag       <= 1'b0;
         fileWrEn       <= 1'b0;
         fileWrAddr     <= 7'h00;
         fileWrData     <= 8'h00;
      end else if (clkEn) begin
         // address and data hold; only the enable pulses
         fileWrEn <= take & destIsFile;
         if (take & destIsFile) begin
            fileWrAddr <= execFileAddr;
            fileWrData <= aluResult;
         end
         if (take & writesAcc) begin
            accOut <= aluResult;
         end else if (apbWr & (paddr == `SXS_REG_ACC)) begin
            accOut <= pwdata[7:0];
         end
         if (take & updCarry) begin
            carryFlag <= aluCarry;
         end else if (apbWr & (paddr == `SXS_REG_STATUS)) begin
            carryFlag <= pwdata[`SXS_ST_CARRY];
         end
         if (take & updDigitCarry) begin
            digitCarryFlag <= aluDigitCarry;
         end else if (apbWr & (paddr == `SXS_REG_STATUS)) begin
            digitCarryFlag <= pwdata[`SXS_ST_DCARRY];
         end
         if (take & updZero) begin
            zeroFlag <= aluZero;
         end else if (apbWr & (paddr == `SXS_REG_STATUS)) begin
            zeroFlag <= pwdata[`SXS_ST_ZERO];
         end
      end
   end

   // ***************************************************
   // direction load decode
   // ***************************************************
   // port a in the lowest slice; other operands load nothing
   localparam [20:0] DIR_SELS = {`SXS_DIR_SEL_C, `SXS_DIR_SEL_B, `SXS_DIR_SEL_A};
   wire [2:0]        dirHit;
   genvar            gi;

   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_dir_hit
         assign dirHit[gi] = take & (execOp == `SXS_OP_DIR_LOAD) & (execFileAddr == DIR_SELS[gi*7 +: 7]);
      end
   endgenerate

   // ***************************************************
   // port direction registers
   // ***************************************************
   // an instruction load beats a bus write
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         portADirection <= `SXS_RST_DIR;
         portBDirection <= `SXS_RST_DIR;
         portCDirection <= `SXS_RST_DIR;
      end else if (clkEn) begin
         if (dirHit[0]) begin
            portADirection <= accOut;
         end else if (apbWr & (paddr == `SXS_REG_DIR_A)) begin
            portADirection <= pwdata[7:0];
         end
         if (dirHit[1]) begin
            portBDirection <= accOut;
         end else if (apbWr & (paddr == `SXS_REG_DIR_B)) begin
            portBDirection <= pwdata[7:0];
         end
         if (dirHit[2]) begin
            portCDirection <= accOut;
         end else if (apbWr & (paddr == `SXS_REG_DIR_C)) begin
            portCDirection <= pwdata[7:0];
         end
      end
   end

   // ***************************************************
   // sleep entry and watchdog
   // ***************************************************
   // the status flags update on the same edge that halts and that drops the
   // oscillator request; sleepEnteredNFlag is only ever restored by reset
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sleepEnteredNFlag   <= 1'b1;
         watchdogExpiryNFlag <= 1'b1;
         haltExec            <= 1'b0;
         oscRun              <= 1'b1;
      end else if (clkEn) begin
         if (sleepOp) begin
            sleepEnteredNFlag   <= 1'b0;
            watchdogExpiryNFlag <= 1'b1;
            haltExec            <= 1'b1;
            oscRun              <= 1'b0;
         // sleep is taken only while awake, so never with a wake
         end else if (wakeUp) begin
            haltExec <= 1'b0;
            oscRun   <= 1'b1;
         end
      end
   end

   // prescaled counter, cleared on sleep entry; it keeps running in sleep and is only read over apb, never used to wake
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         watchPre_r      <= {WATCH_PRE_W{1'b0}};
         watchdogCounter <= {WATCH_CNT_W{1'b0}};
      end else if (clkEn) begin
         if (sleepOp) begin
            watchPre_r      <= {WATCH_PRE_W{1'b0}};
            watchdogCounter <= {WATCH_CNT_W{1'b0}};
         end else begin
            watchPre_r <= watchPre_r + {{(WATCH_PRE_W-1){1'b0}}, 1'b1};
            if (&watchPre_r) begin
               watchdogCounter <= watchdogCounter + {{(WATCH_CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // sxs_exec

// ===== inc/sxs_consts.vh
// constants for the subtract/xor/swap/sleep execution slice
// assumes a 32-bit apb register window and a 4-bit decoded opcode from the core decoder
`ifndef SXS_CONSTS_VH
`define SXS_CONSTS_VH

// ***************************************************
// decoded operation codes
// ***************************************************
`define SXS_OP_NONE        4'h0
`define SXS_OP_LIT_SUB     4'h1
`define SXS_OP_FILE_SUB    4'h2
`define SXS_OP_FILE_SUBB   4'h3
`define SXS_OP_NIB_SWAP    4'h4
`define SXS_OP_XOR_LIT     4'h5
`define SXS_OP_XOR_FILE    4'h6
`define SXS_OP_DIR_LOAD    4'h7
`define SXS_OP_SLEEP       4'h8
`define SXS_OP_ROT_RIGHT   4'h9

// ***************************************************
// direction-load operand values
// ***************************************************
`define SXS_DIR_SEL_A      7'h05
`define SXS_DIR_SEL_B      7'h06
`define SXS_DIR_SEL_C      7'h07

// ***************************************************
// apb register byte offsets
// ***************************************************
`define SXS_REG_ACC        8'h00
`define SXS_REG_STATUS     8'h04
`define SXS_REG_DIR_A      8'h08
`define SXS_REG_DIR_B      8'h0C
`define SXS_REG_DIR_C      8'h10
`define SXS_REG_SLEEP      8'h14
`define SXS_REG_WATCH      8'h18

// ***************************************************
// status and sleep register fields
// ***************************************************
`define SXS_ST_CARRY       0
`define SXS_ST_DCARRY      1
`define SXS_ST_ZERO        2
`define SXS_ST_SLEEP_N     3
`define SXS_ST_EXPIRY_N    4
`define SXS_SLP_ASLEEP     0

// ***************************************************
// reset values
// ***************************************************
`define SXS_RST_ACC        8'h00
`define SXS_RST_DIR        8'hFF
`define SXS_RST_WATCH      8'h00

`endif

// ===== hw/sxs_rst_sync.v
// two-stage release synchroniser for the active-low asynchronous reset
// assumes arst_n may drop at any time; release is aligned to core_clk
`timescale 1ns/1ns
module sxs_rst_sync (
   // clock and raw reset
   input  wire core_clk,
   input  wire arst_n,
   // synchronised reset
   output wire rstSync_n
);
   reg stage1_r;
   reg stage2_r;

   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1_r <= 1'b0;
         stage2_r <= 1'b0;
      end else begin
         stage1_r <= 1'b1;
         stage2_r <= stage1_r;
      end
   end

   assign rstSync_n = stage2_r;
endmodule // sxs_rst_sync

// ===== hw/sxs_alu.v
// combinational result and flag logic for one executed instruction
// assumes operands are stable for the cycle in which the instruction is taken
`timescale 1ns/1ns
`include "sxs_consts.vh"
module sxs_alu (
   // operands
   input  wire [3:0] op,
   input  wire [7:0] acc,
   input  wire [7:0] fileVal,
   input  wire [7:0] lit,
   input  wire       carryIn,
   // results
   output reg  [7:0] result,
   output reg        carryOut,
   output reg        digitCarryOut,
   output wire       zeroOut,
   output reg        updCarry,
   output reg        updDigitCarry,
   output reg        updZero
);
   wire [7:0] minuend;
   wire       borrowIn;
   wire [8:0] diffFull;
   wire [4:0] diffLow;

   // the literal form takes the literal as minuend, the file forms the file value
   assign minuend  = (op == `SXS_OP_LIT_SUB) ? lit : fileVal;
   assign borrowIn = (op == `SXS_OP_FILE_SUBB) ? ~carryIn : 1'b0;
   assign diffFull = {1'b0, minuend} - {1'b0, acc} - {8'h00, borrowIn};
   assign diffLow  = {1'b0, minuend[3:0]} - {1'b0, acc[3:0]} - {4'h0, borrowIn};
   assign zeroOut  = (result == 8'h00);

   always @* begin
      result        = acc;
      carryOut      = carryIn;
      digitCarryOut = 1'b0;
      updCarry      = 1'b0;
      updDigitCarry = 1'b0;
      updZero       = 1'b0;
      case (op)
         `SXS_OP_LIT_SUB, `SXS_OP_FILE_SUB, `SXS_OP_FILE_SUBB: begin
            result        = diffFull[7:0];
            carryOut      = ~diffFull[8];
            digitCarryOut = ~diffLow[4];
            updCarry      = 1'b1;
            updDigitCarry = 1'b1;
            updZero       = 1'b1;
         end
         `SXS_OP_NIB_SWAP: begin
            result = {fileVal[3:0], fileVal[7:4]};
         end
         `SXS_OP_XOR_LIT: begin
            result  = acc ^ lit;
            updZero = 1'b1;
         end
         `SXS_OP_XOR_FILE: begin
            result  = acc ^ fileVal;
            updZero = 1'b1;
         end
         `SXS_OP_ROT_RIGHT: begin
            result   = {carryIn, fileVal[7:1]};
            carryOut = fileVal[0];
            updCarry = 1'b1;
         end
         default: begin
            result = acc;
         end
      endcase
   end
endmodule // sxs_alu

// ===== dv/sxs_exec_asserts.sv
// concurrent checks on the execution slice ports
// assumes bind into sxs_exec; apb writes never share a cycle with an instruction
`timescale 1ns/1ns
`include "sxs_consts.vh"
module sxs_exec_asserts (
   // clock and reset
   input wire       core_clk,
   input wire       arst_n,
   // instruction side
   input wire       clkEn,
   input wire       execValid,
   input wire [3:0] execOp,
   input wire [7:0] execLit,
   input wire [6:0] execFileAddr,
   input wire       execDest,
   input wire [7:0] fileRdData,
   input wire       execReady,
   input wire       fileWrEn,
   input wire [6:0] fileWrAddr,
   input wire [7:0] fileWrData,
   // core state
   input wire [7:0] accOut,
   input wire       carryFlag,
   input wire       digitCarryFlag,
   input wire       zeroFlag,
   input wire       sleepEnteredNFlag,
   input wire       watchdogExpiryNFlag,
   input wire [7:0] portADirection,
   input wire       haltExec,
   input wire       oscRun
);
   wire tk = clkEn && execValid && execReady;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   a_lit_sub: assert property (tk && execOp == `SXS_OP_LIT_SUB |=> accOut == $past(execLit) - $past(accOut))
      else $error("literal subtract result wrong");
   a_lit_flags: assert property (tk && execOp == `SXS_OP_LIT_SUB |=>
      carryFlag == ($past(accOut) <= $past(execLit)) && digitCarryFlag == ($past(accOut[3:0]) <= $past(execLit[3:0])))
      else $error("subtract carry flags wrong");
   a_file_wback: assert property (tk && execOp == `SXS_OP_FILE_SUB && execDest |=> fileWrEn &&
      fileWrAddr == $past(execFileAddr) && fileWrData == $past(fileRdData) - $past(accOut))
      else $error("file subtract write-back wrong");
   a_acc_dest: assert property (tk && !execDest |=> !fileWrEn)
      else $error("file written for accumulator destination");
   a_borrow_sub: assert property (tk && execOp == `SXS_OP_FILE_SUBB && !execDest |=>
      accOut == $past(fileRdData) - $past(accOut) - {7'h00, !$past(carryFlag)})
      else $error("borrow subtract result wrong");
   a_swap_keep: assert property (tk && execOp == `SXS_OP_NIB_SWAP && execDest |=>
      $stable({carryFlag, digitCarryFlag, zeroFlag}) && fileWrData == {$past(fileRdData[3:0]), $past(fileRdData[7:4])})
      else $error("nibble swap wrong");
   a_xor_zero: assert property (tk && execOp == `SXS_OP_XOR_LIT |=> accOut == ($past(accOut) ^ $past(execLit)) &&
      zeroFlag == (accOut == 8'h00) && $stable(carryFlag))
      else $error("xor literal wrong");
   a_sleep_entry: assert property (tk && execOp == `SXS_OP_SLEEP |=> haltExec && !oscRun &&
      !sleepEnteredNFlag && watchdogExpiryNFlag && !execReady)
      else $error("sleep entry wrong");
   a_dir_load: assert property (tk && execOp == `SXS_OP_DIR_LOAD && execFileAddr == `SXS_DIR_SEL_A |=>
      portADirection == $past(accOut))
      else $error("direction load wrong");
   a_rot_right: assert property (tk && execOp == `SXS_OP_ROT_RIGHT && execDest |=>
      fileWrData == {$past(carryFlag), $past(fileRdData[7:1])} && carryFlag == $past(fileRdData[0]))
      else $error("rotate right wrong");
   c_sleep: cover property (tk && execOp == `SXS_OP_SLEEP);
   c_borrow: cover property (tk && execOp == `SXS_OP_FILE_SUBB && !carryFlag);
   c_wback: cover property (fileWrEn ##1 fileWrEn);
endmodule // sxs_exec_asserts
bind sxs_exec sxs_exec_asserts u_chk (.core_clk, .arst_n, .clkEn, .execValid, .execOp, .execLit, .execFileAddr,
   .execDest, .fileRdData, .execReady, .fileWrEn, .fileWrAddr, .fileWrData, .accOut, .carryFlag, .digitCarryFlag,
   .zeroFlag, .sleepEnteredNFlag, .watchdogExpiryNFlag, .portADirection, .haltExec, .oscRun);

// ===== dv/sxs_regfile_model.sv
// register file on the far side of the instruction port
// assumes write-back pulses from sxs_exec; forwards a write to a read of the same cell
`timescale 1ns/1ns
module sxs_regfile_model (
   // clock
   input  wire       core_clk,
   // read side
   input  wire       execValid,
   input  wire [6:0] execFileAddr,
   output wire [7:0] fileRdData,
   // write side
   input  wire       fileWrEn,
   input  wire [6:0] fileWrAddr,
   input  wire [7:0] fileWrData
);
   logic [7:0] mem [0:127];
   wire  [7:0] cur = (fileWrEn && fileWrAddr == execFileAddr) ? fileWrData : mem[execFileAddr];
   initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
   // outside a strobe the bus shows inverted data so a stale sample cannot match
   assign fileRdData = execValid ? cur : ~cur;
   always @(posedge core_clk) if (fileWrEn) mem[fileWrAddr] <= fileWrData;
endmodule // sxs_regfile_model

// ===== dv/tb_top.sv
// self-checking bench for the execution slice
// assumes sxs_regfile_model as far side; checker attached by bind
`timescale 1ns/1ns
`include "sxs_consts.vh"
module tb_top;
   typedef struct packed {logic [7:0] acc; logic c, dc, z, we; logic [6:0] wa; logic [7:0] wd, da, db, dq;} sxs_exp_t;
   logic core_clk, arst_n, clkEn, execValid, execDest, wakeReq, psel, penable, pwrite, tookQ;
   logic [3:0] execOp;
   logic [7:0] execLit, paddr, sAcc;
   logic [6:0] execFileAddr;
   logic [31:0] pwdata, rv;
   logic sC, sDc, sZ, ev;
   logic [7:0] sMem [0:127];
   logic [7:0] sDir [0:2];
   logic [3:0] opTab [0:7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9};
   sxs_exp_t expQ [$];
   sxs_exp_t e;
   int fail_count = 0;
   int n_compared = 0;
   int k;
   wire [7:0] fileRdData, fileWrData, accOut, portADirection, portBDirection, portCDirection;
   wire [6:0] fileWrAddr;
   wire [31:0] prdata;
   wire execReady, fileWrEn, carryFlag, digitCarryFlag, zeroFlag, sleepEnteredNFlag, watchdogExpiryNFlag;
   wire haltExec, oscRun, pready, pslverr;
   sxs_exec uut (.core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn), .execValid(execValid), .execOp(execOp),
      .execLit(execLit), .execFileAddr(execFileAddr), .execDest(execDest), .fileRdData(fileRdData),
      .execReady(execReady), .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr), .fileWrData(fileWrData), .accOut(accOut),
      .carryFlag(carryFlag), .digitCarryFlag(digitCarryFlag), .zeroFlag(zeroFlag), .sleepEnteredNFlag(sleepEnteredNFlag),
      .watchdogExpiryNFlag(watchdogExpiryNFlag), .portADirection(portADirection), .portBDirection(portBDirection),
      .portCDirection(portCDirection), .haltExec(haltExec), .oscRun(oscRun), .wakeReq(wakeReq), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr));
   sxs_regfile_model u_rf (.core_clk(core_clk), .execValid(execValid), .execFileAddr(execFileAddr),
      .fileRdData(fileRdData), .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr), .fileWrData(fileWrData));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cmpVal(input string nm, input logic [63:0] ex, input logic [63:0] gt);
      n_compared++;
      if (gt !== ex) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, ex, gt);
      end
   endtask
   // ops: 1 lit-acc, 2 file-acc, 3 with borrow, 4 swap, 5 xor lit, 6 xor file, 7 dir load, 8 sleep, 9 rotate
   task automatic issue(input logic [3:0] op, input logic [7:0] lit, input logic [6:0] ad, input logic d);
      logic [8:0] r;
      logic [4:0] n;
      logic [7:0] f;
      logic we;
      f = sMem[ad];
      r = 9'h000;
      n = 5'h00;
      case (op)
         4'h1: begin
            r = {1'b0, lit} - {1'b0, sAcc};
            n = {1'b0, lit[3:0]} - {1'b0, sAcc[3:0]};
         end
         4'h2, 4'h3: begin
            r = {1'b0, f} - {1'b0, sAcc} - {8'h00, op == 4'h3 && !sC};
            n = {1'b0, f[3:0]} - {1'b0, sAcc[3:0]} - {4'h0, op == 4'h3 && !sC};
         end
         4'h4: r = {1'b0, f[3:0], f[7:4]};
         4'h5: r = {1'b0, sAcc ^ lit};
         4'h6: r = {1'b0, sAcc ^ f};
         4'h9: r = {f[0], sC, f[7:1]};
         default: r = 9'h000;
      endcase
      if (op inside {4'h1, 4'h2, 4'h3}) begin
         sC = !r[8];
         sDc = !n[4];
      end
      if (op == 4'h9) sC = r[8];
      if (op inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6}) sZ = (r[7:0] == 8'h00);
      we = d && (op inside {4'h2, 4'h3, 4'h4, 4'h6, 4'h9});
      if (we) sMem[ad] = r[7:0];
      else if (op inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9}) sAcc = r[7:0];
      if (op == 4'h7 && ad >= 7'h05 && ad <= 7'h07) sDir[ad - 7'h05] = sAcc;
      expQ.push_back({sAcc, sC, sDc, sZ, we, ad, r[7:0], sDir[0], sDir[1], sDir[2]});
      execOp <= op;
      execLit <= lit;
      execFileAddr <= ad;
      execDest <= d;
      execValid <= 1'b1;
      @(posedge core_clk);
   endtask
   task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      penable <= 1'b0;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail_count++;
         tally_and_finish;
      end
      @(posedge core_clk);
   endtask
   task automatic apbRead(input string nm, input logic [7:0] a, input logic [7:0] ex, input logic ee);
      apbXfer(1'b0, a, 32'h0);
      cmpVal(nm, {24'h0, ex, ee}, {rv, ev});
   endtask
   always @(posedge core_clk) tookQ <= clkEn && execValid && execReady;
   always @(negedge core_clk) begin
      if (tookQ === 1'b1) begin
         if (expQ.size() == 0) cmpVal("queue", 1, 0);
         else begin
            e = expQ.pop_front();
            cmpVal("acc_flags", {e.acc, e.c, e.dc, e.z}, {accOut, carryFlag, digitCarryFlag, zeroFlag});
            cmpVal("file_wr", {e.we, e.we ? {e.wa, e.wd} : 15'h0}, {fileWrEn, e.we ? {fileWrAddr, fileWrData} : 15'h0});
            cmpVal("dirs", {e.da, e.db, e.dq}, {portADirection, portBDirection, portCDirection});
         end
      end
   end
   initial begin
      {arst_n, execValid, execOp, execLit, execFileAddr, execDest, wakeReq, psel, penable, pwrite, paddr, pwdata} = '0;
      clkEn = 1'b1;
      tookQ = 1'b0;
      {sAcc, sC, sDc, sZ} = '0;
      sDir = '{8'hFF, 8'hFF, 8'hFF};
      for (int i = 0; i < 128; i++) sMem[i] = 8'(i * 37 + 5);
      void'($urandom(32'h221dfd10));
      repeat (12) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      apbRead("status_rst", `SXS_REG_STATUS, 8'h18, 1'b0);
      apbRead("dirb_rst", `SXS_REG_DIR_B, 8'hFF, 1'b0);
      apbRead("unmapped", 8'h40, 8'h00, 1'b1);
      sAcc = 8'($urandom);
      apbXfer(1'b1, `SXS_REG_ACC, {24'h0, sAcc});
      issue(4'h1, sAcc, 7'h00, 1'b0);
      issue(4'h5, 8'h80, 7'h00, 1'b0);
      issue(4'h1, 8'h7F, 7'h00, 1'b0);
      issue(4'h3, 8'h00, 7'h11, 1'b1);
      for (int i = 0; i < 300; i++) issue(opTab[$urandom % 8], 8'($urandom),
         7'($urandom % 128), 1'($urandom));
      for (int i = 4; i < 8; i++) issue(4'h7, 8'h00, 7'(i), 1'b0);
      execValid <= 1'b0;
      // past one prescaler wrap, so the clear on sleep shows
      apbRead("watch_run", `SXS_REG_WATCH, 8'h01, 1'b0);
      issue(4'h8, 8'h00, 7'h00, 1'b0);
      execValid <= 1'b0;
      @(negedge core_clk);
      cmpVal("sleep", {haltExec, oscRun, sleepEnteredNFlag, watchdogExpiryNFlag, execReady}, 5'b10010);
      @(posedge core_clk);
      apbRead("watch", `SXS_REG_WATCH, 8'h00, 1'b0);
      apbRead("status", `SXS_REG_STATUS, {3'h0, 2'b10, sZ, sDc, sC}, 1'b0);
      // an instruction offered while asleep must leave the accumulator alone
      execOp <= 4'h5;
      execLit <= 8'hFF;
      execValid <= 1'b1;
      @(posedge core_clk);
      execValid <= 1'b0;
      @(posedge core_clk);
      apbRead("acc_asleep", `SXS_REG_ACC, sAcc, 1'b0);
      wakeReq <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (haltExec !== 1'b0 && k < 20);
      wakeReq <= 1'b0;
      if (haltExec !== 1'b0) begin
         fail_count++;
         tally_and_finish;
      end
      cmpVal("awake", {haltExec, oscRun, execReady}, 3'b011);
      // leave sleep through the bus
      issue(4'h8, 8'h00, 7'h00, 1'b0);
      execValid <= 1'b0;
      apbRead("asleep", `SXS_REG_SLEEP, 8'h01, 1'b0);
      apbXfer(1'b1, `SXS_REG_SLEEP, 32'h0000_0001);
      cmpVal("bus_wake", {haltExec, oscRun, execReady}, 3'b011);
      issue(4'h6, 8'h00, 7'h22, 1'b1);
      execValid <= 1'b0;
      repeat (2) @(posedge core_clk);
      tally_and_finish;
   end
endmodule // tb_top
